// *** rtl/cpf_pkg.sv ***
package cpf_pkg;

  // Register port geometry and register indices.
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] PROT_IDX = 4'h0;
  localparam logic [ADDR_W-1:0] ADC_CFG_IDX = 4'h1;
  localparam logic [ADDR_W-1:0] TEMP_CFG_IDX = 4'h2;

  // Protection register fields.
  localparam int CHARGE_OVERCURRENT_FLAG_BIT = 15;
  localparam int DISCHARGE_OVERCURRENT_FLAG_BIT = 14;
  localparam int SCF_BIT = 13;
  localparam int OVF_BIT = 12;
  localparam int UVF_BIT = 11;
  localparam int CHG_MIRROR_BIT = 9;
  localparam int DSG_MIRROR_BIT = 8;
  localparam int CE_BIT = 3;
  localparam int DE_BIT = 2;
  localparam int PMM_LSB = 0;
  localparam logic [DATA_W-1:0] PROT_RESET = 16'h000F;

  // Converter configuration fields.
  localparam int CHARGE_OC_THRESHOLD_SEL_LSB = 6;
  localparam int DISCHARGE_OC_THRESHOLD_SEL_LSB = 4;
  localparam int SHORT_DELAY_SEL_BIT = 3;
  localparam logic [DATA_W-1:0] ADC_CFG_WMASK = 16'hFFF9;
  localparam logic [DATA_W-1:0] ADC_CFG_RESET = 16'h0000;

  // Temperature configuration fields.
  localparam int TLE_BIT = 2;
  localparam int TLS_LSB = 0;
  localparam logic [DATA_W-1:0] TEMP_CFG_RESET = 16'h0000;

  // Protection and measurement mode encodings.
  typedef enum logic [1:0] {
    PMM_OFF = 2'h0,
    PMM_ADC_A = 2'h1,
    PMM_ADC_B = 2'h2,
    PMM_RUN = 2'h3
  } cpf_pmm_t;

  // Clock period and protection delays in nanoseconds.
  localparam int CLK_PERIOD_NS = 50;
  localparam int T_OVD_NS = 1000000;
  localparam int T_UVD_NS = 1000000;
  localparam int T_OCD_NS = 10000;
  localparam int T_SCD_SHORT_NS = 250000;
  localparam int T_SCD_LONG_NS = 2000000;
  localparam int T_SSCD_NS = 100000;
  localparam int SYNC_LAT_CYC = 2;
  // Least times round up; the secondary path is a longest time.
  localparam int OVD_CYC = (T_OVD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int UVD_CYC = (T_UVD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OCD_CYC = (T_OCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCD_SHORT_CYC =
      (T_SCD_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCD_LONG_CYC =
      (T_SCD_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SSCD_CYC = T_SSCD_NS / CLK_PERIOD_NS - SYNC_LAT_CYC - 2;

  // Temperature limits in eighths of a degree, per limit select code.
  function automatic logic signed [DATA_W-1:0] temp_lim(
      input logic [1:0] sel, input logic [1:0] which);
    logic signed [DATA_W-1:0] t [4][4];
    t = '{'{-16'sd24, 16'sd424, -16'sd184, 16'sd504},
          '{-16'sd24, 16'sd464, -16'sd184, 16'sd544},
          '{-16'sd184, 16'sd584, -16'sd184, 16'sd584},
          '{-16'sd344, 16'sd704, -16'sd344, 16'sd704}};
    return t[sel][which];
  endfunction

  // Column order of the limit table.
  localparam logic [1:0] LIM_CL = 2'h0;
  localparam logic [1:0] LIM_CH = 2'h1;
  localparam logic [1:0] LIM_DL = 2'h2;
  localparam logic [1:0] LIM_DH = 2'h3;

endpackage

// *** rtl/cpf_protect.sv ***
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
// How it works
// - Overvoltage held past its delay drops charge gate, sets flag.
// - Overvoltage releases when cell falls below charge-enable level.
// - Overvoltage also releases early on discharge sense at -2mV or less.
// - Undervoltage held past its delay drops both gates, sets flag.
// - Recovery charge path on only while cell is 0 to charge-enable.
// - Undervoltage releases once cell rises above undervoltage level.
// - Charge overcurrent held past its delay drops both gates, sets flag.
// - Charge overcurrent holds, pulldown on, until pack terminal falls.
// - Charge overcurrent threshold picked by two-bit config field.
// - Discharge overcurrent held past delay drops discharge gate, sets flag.
// - Discharge overcurrent or short holds, pullup on, until pack rises.
// - Discharge field picks both thresholds; one bit picks short delay.
// - Short circuit held past selected delay drops discharge gate, flag.
// - Collapsed supply drops the discharge gate within the secondary delay.
// - Temperature gating only when enabled; select picks four limits.
// - Temperature faults apply at each result update, no delay, no hysteresis.
// - Charge gate low when too hot or at/below low charge limit.
// - Discharge gate low when too hot or at/below low discharge limit.
// - Each gate is the AND of none of the faults that drop it, its enable, mode 11, and not sleeping.
// - Flags are sticky; software clears one only after its fault is gone.
// - Enable bit high never overrides an active fault.
// - Mode 00 converter off, 01/10 on with gates low, 11 gates free.
module cpf_protect #(
  parameter int OVD_CYC = cpf_pkg::OVD_CYC,
  parameter int UVD_CYC = cpf_pkg::UVD_CYC,
  parameter int OCD_CYC = cpf_pkg::OCD_CYC,
  parameter int SCD_SHORT_CYC = cpf_pkg::SCD_SHORT_CYC,
  parameter int SCD_LONG_CYC = cpf_pkg::SCD_LONG_CYC,
  parameter int SSCD_CYC = cpf_pkg::SSCD_CYC
) (
  // Clock and reset.
  input wire logic CLK,
  input wire logic RST,
  // Register port.
  input wire logic [cpf_pkg::ADDR_W-1:0] ADDR,
  input wire logic [cpf_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [cpf_pkg::DATA_W-1:0] RDATA,
  // Cell voltage comparators.
  input wire logic CELL_ABOVE_OV,
  input wire logic CELL_BELOW_CE,
  input wire logic CELL_BELOW_UV,
  input wire logic CELL_NONNEG,
  // Sense voltage comparators, one per threshold select code, and the single -2mV discharge level.
  input wire logic [3:0] SENSE_ABOVE_COC,
  input wire logic [3:0] SENSE_BELOW_NOC,
  input wire logic [3:0] SENSE_ABOVE_SC,
  input wire logic SENSE_DISCHG_2MV,
  // Pack terminal and supply comparators.
  input wire logic PACK_TERMINAL_LOW,
  input wire logic PACK_TERMINAL_HIGH,
  input wire logic SUPPLY_COLLAPSED,
  // Temperature result from the converter and the sleep request, same clock.
  input wire logic signed [cpf_pkg::DATA_W-1:0] TEMP_VALUE,
  input wire logic TEMP_UPDATE,
  input wire logic SLEEP,
  // Gate drive, pack terminal test currents, recovery path and converter enable.
  output logic CHARGE_GATE_OUT,
  output logic DISCHARGE_GATE_OUT,
  output logic PACK_PULLDOWN_EN,
  output logic PACK_PULLUP_EN,
  output logic RECOVERY_EN,
  output logic ADC_EN
);

  localparam int QW = 16;

  logic [19:0] raw;
  logic [19:0] syn;
  logic ov_c, below_ce, uv_c, nonneg, dsg_2mv, pack_low, pack_high, collapse;
  logic [3:0] coc_v, noc_v, sc_v;
  logic [cpf_pkg::DATA_W-1:0] prot_q, adc_cfg_q, temp_cfg_q;
  logic [4:0] flags_q;
  logic ov_trip_q, uv_trip_q, coc_trip_q, doc_trip_q, sc_trip_q;
  logic ov_fire, uv_fire, coc_fire, doc_fire, sc_fire, ssc_fire;
  logic coc_c, doc_c, sc_c;
  logic [QW-1:0] sc_lim;
  logic temp_chg_q, temp_dis_q, temp_en;
  logic [1:0] temp_sel;
  logic chg_ok, dis_ok;
  logic [4:0] fault_now, flag_set, flag_clr;
  logic wr_prot;
  logic [QW-1:0] collapse_cnt_q;
  cpf_pkg::cpf_pmm_t protect_measure_mode;

  // All comparator levels come from the analog side and need resynchronising.
  assign raw = {CELL_ABOVE_OV, CELL_BELOW_CE, CELL_BELOW_UV, CELL_NONNEG,
                SENSE_ABOVE_COC, SENSE_BELOW_NOC, SENSE_ABOVE_SC,
                SENSE_DISCHG_2MV, PACK_TERMINAL_LOW, PACK_TERMINAL_HIGH,
                SUPPLY_COLLAPSED};

  cpf_sync #(.W(20)) u_sync (
    .clk(CLK),
    .rst(RST),
    .d(raw),
    .q(syn)
  );

  // Unpack the synchronised bundle in the same order.
  assign {ov_c, below_ce, uv_c, nonneg, coc_v, noc_v, sc_v, dsg_2mv,
          pack_low, pack_high, collapse} = syn;

  // Configuration fields steer the comparator selection and the delays.
  assign coc_c = coc_v[adc_cfg_q[cpf_pkg::CHARGE_OC_THRESHOLD_SEL_LSB +: 2]];
  assign doc_c = noc_v[adc_cfg_q[cpf_pkg::DISCHARGE_OC_THRESHOLD_SEL_LSB +: 2]];
  assign sc_c = sc_v[adc_cfg_q[cpf_pkg::DISCHARGE_OC_THRESHOLD_SEL_LSB +: 2]];
  assign sc_lim = adc_cfg_q[cpf_pkg::SHORT_DELAY_SEL_BIT] ? QW'(SCD_LONG_CYC)
                                               : QW'(SCD_SHORT_CYC);
  assign temp_en = temp_cfg_q[cpf_pkg::TLE_BIT];
  assign temp_sel = temp_cfg_q[cpf_pkg::TLS_LSB +: 2];
  assign protect_measure_mode = cpf_pkg::cpf_pmm_t'(prot_q[cpf_pkg::PMM_LSB +: 2]);
  assign wr_prot = WR && (ADDR == cpf_pkg::PROT_IDX);

  // Delay qualifiers, one per timed fault.
  cpf_qualify #(.W(QW)) u_ov (
    .clk(CLK), .rst(RST), .cond(ov_c), .limit(QW'(OVD_CYC)), .fired(ov_fire)
  );
  cpf_qualify #(.W(QW)) u_uv (
    .clk(CLK), .rst(RST), .cond(uv_c), .limit(QW'(UVD_CYC)), .fired(uv_fire)
  );
  cpf_qualify #(.W(QW)) u_coc (
    .clk(CLK), .rst(RST), .cond(coc_c), .limit(QW'(OCD_CYC)),
    .fired(coc_fire)
  );
  cpf_qualify #(.W(QW)) u_doc (
    .clk(CLK), .rst(RST), .cond(doc_c), .limit(QW'(OCD_CYC)),
    .fired(doc_fire)
  );
  cpf_qualify #(.W(QW)) u_sc (
    .clk(CLK), .rst(RST), .cond(sc_c), .limit(sc_lim), .fired(sc_fire)
  );
  cpf_qualify #(.W(QW)) u_ssc (
    .clk(CLK), .rst(RST), .cond(collapse), .limit(QW'(SSCD_CYC)),
    .fired(ssc_fire)
  );

  // Overvoltage trip; a new trip wins over a release in the same cycle.
  always_ff @(posedge CLK) begin
    if (RST) begin
      ov_trip_q <= 1'b0;
    end else if (ov_fire) begin
      ov_trip_q <= 1'b1;
    end else if (below_ce || dsg_2mv) begin
      ov_trip_q <= 1'b0;
    end
  end

  // Undervoltage trip, released once the cell climbs back over the level.
  always_ff @(posedge CLK) begin
    if (RST) begin
      uv_trip_q <= 1'b0;
    end else if (uv_fire) begin
      uv_trip_q <= 1'b1;
    end else if (!uv_c) begin
      uv_trip_q <= 1'b0;
    end
  end

  // Charge overcurrent waits for the pulldown to drag the pack terminal low.
  always_ff @(posedge CLK) begin
    if (RST) begin
      coc_trip_q <= 1'b0;
    end else if (coc_fire) begin
      coc_trip_q <= 1'b1;
    end else if (pack_low) begin
      coc_trip_q <= 1'b0;
    end
  end

  // Discharge overcurrent and short wait for the pullup to lift the terminal.
  always_ff @(posedge CLK) begin
    if (RST) begin
      doc_trip_q <= 1'b0;
      sc_trip_q <= 1'b0;
    end else begin
      if (doc_fire) begin
        doc_trip_q <= 1'b1;
      end else if (pack_high) begin
        doc_trip_q <= 1'b0;
      end
      if (sc_fire || ssc_fire) begin
        sc_trip_q <= 1'b1;
      end else if (pack_high) begin
        sc_trip_q <= 1'b0;
      end
    end
  end

  // Temperature is judged only at result updates, with no hysteresis.
  always_ff @(posedge CLK) begin
    if (RST) begin
      temp_chg_q <= 1'b0;
      temp_dis_q <= 1'b0;
    end else if (TEMP_UPDATE) begin
      temp_chg_q <=
          (TEMP_VALUE > cpf_pkg::temp_lim(temp_sel, cpf_pkg::LIM_CH)) ||
          (TEMP_VALUE <= cpf_pkg::temp_lim(temp_sel, cpf_pkg::LIM_CL));
      temp_dis_q <=
          (TEMP_VALUE > cpf_pkg::temp_lim(temp_sel, cpf_pkg::LIM_DH)) ||
          (TEMP_VALUE <= cpf_pkg::temp_lim(temp_sel, cpf_pkg::LIM_DL));
    end
  end

  // Gate permission is a plain AND; nothing software writes can bypass it.
  always_comb begin
    chg_ok = !ov_trip_q && !uv_trip_q && !coc_trip_q &&
             !(temp_en && temp_chg_q) &&
             prot_q[cpf_pkg::CE_BIT] && !SLEEP &&
             (protect_measure_mode == cpf_pkg::PMM_RUN);
    dis_ok = !uv_trip_q && !coc_trip_q && !doc_trip_q && !sc_trip_q &&
             !(temp_en && temp_dis_q) &&
             prot_q[cpf_pkg::DE_BIT] && !SLEEP &&
             (protect_measure_mode == cpf_pkg::PMM_RUN);
  end

  // Pin drivers are registered so that every output comes from a flop.
  always_ff @(posedge CLK) begin
    if (RST) begin
      CHARGE_GATE_OUT <= 1'b0;
      DISCHARGE_GATE_OUT <= 1'b0;
      PACK_PULLDOWN_EN <= 1'b0;
      PACK_PULLUP_EN <= 1'b0;
      RECOVERY_EN <= 1'b0;
      ADC_EN <= 1'b0;
    end else begin
      CHARGE_GATE_OUT <= chg_ok;
      DISCHARGE_GATE_OUT <= dis_ok;
      PACK_PULLDOWN_EN <= coc_trip_q;
      PACK_PULLUP_EN <= doc_trip_q || sc_trip_q;
      RECOVERY_EN <= nonneg && below_ce;
      ADC_EN <= (protect_measure_mode != cpf_pkg::PMM_OFF);
    end
  end

  // Sticky flags in CHARGE_OVERCURRENT_FAULT, DISCHARGE_OVERCURRENT_FAULT, SC, OV, UV order, matching bits 15 to 11.
  assign flag_set = {coc_fire, doc_fire, sc_fire || ssc_fire, ov_fire,
                     uv_fire};
  assign fault_now = {coc_trip_q || coc_c, doc_trip_q || doc_c,
                      sc_trip_q || sc_c || collapse, ov_trip_q || ov_c,
                      uv_trip_q || uv_c};
  // Writing zero clears a flag only once its fault is fully gone.
  assign flag_clr = wr_prot ? (~WDATA[cpf_pkg::CHARGE_OVERCURRENT_FLAG_BIT -: 5] & ~fault_now)
                            : 5'h00;

  always_ff @(posedge CLK) begin
    if (RST) begin
      flags_q <= 5'h00;
    end else begin
      flags_q <= flag_set | (flags_q & ~flag_clr);
    end
  end

  // Software-owned control fields; reserved bits are not stored.
  always_ff @(posedge CLK) begin
    if (RST) begin
      prot_q <= cpf_pkg::PROT_RESET;
      adc_cfg_q <= cpf_pkg::ADC_CFG_RESET;
      temp_cfg_q <= cpf_pkg::TEMP_CFG_RESET;
    end else if (WR) begin
      if (ADDR == cpf_pkg::PROT_IDX) begin
        prot_q <= {12'h000, WDATA[3:0]};
      end
      if (ADDR == cpf_pkg::ADC_CFG_IDX) begin
        adc_cfg_q <= WDATA & cpf_pkg::ADC_CFG_WMASK;
      end
      if (ADDR == cpf_pkg::TEMP_CFG_IDX) begin
        temp_cfg_q <= {13'h0000, WDATA[2:0]};
      end
    end
  end

  // Read data stands in the cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge CLK) begin
    if (RST) begin
      RDATA <= '0;
    end else if (RD) begin
      case (ADDR)
        cpf_pkg::PROT_IDX: begin
          RDATA <= {flags_q, 1'b0, CHARGE_GATE_OUT, DISCHARGE_GATE_OUT,
                    prot_q[7:0]};
        end
        cpf_pkg::ADC_CFG_IDX: begin
          RDATA <= adc_cfg_q;
        end
        cpf_pkg::TEMP_CFG_IDX: begin
          RDATA <= temp_cfg_q;
        end
        default: begin
          RDATA <= '0;
        end
      endcase
    end else begin
      RDATA <= '0;
    end
  end

  // Checks on gate behaviour against the fault state.
  ov_blocks_chg_a: assert property (@(posedge CLK) disable iff (RST)
    $rose(ov_trip_q) |=> !CHARGE_GATE_OUT [*2])
    else $error("Charge gate high during overvoltage.");

  ov_release_a: assert property (@(posedge CLK) disable iff (RST)
    ov_trip_q && !ov_fire && $past(below_ce) && below_ce |=> !ov_trip_q)
    else $error("Overvoltage not released below charge level.");

  ov_early_a: assert property (@(posedge CLK) disable iff (RST)
    ov_trip_q && dsg_2mv && !ov_fire |=> !ov_trip_q)
    else $error("Overvoltage not released on discharge.");

  uv_both_off_a: assert property (@(posedge CLK) disable iff (RST)
    uv_trip_q |=> !CHARGE_GATE_OUT && !DISCHARGE_GATE_OUT)
    else $error("Gate high during undervoltage.");

  recovery_path_a: assert property (@(posedge CLK) disable iff (RST)
    RECOVERY_EN |-> $past(nonneg) && $past(below_ce))
    else $error("Recovery path on outside its window.");

  coc_pulldown_a: assert property (@(posedge CLK) disable iff (RST)
    coc_trip_q |=> PACK_PULLDOWN_EN && !CHARGE_GATE_OUT)
    else $error("Charge overcurrent without pulldown.");

  dsg_pullup_a: assert property (@(posedge CLK) disable iff (RST)
    (doc_trip_q || sc_trip_q) |=> PACK_PULLUP_EN && !DISCHARGE_GATE_OUT)
    else $error("Discharge fault without pullup.");

  sc_delay_a: assert property (@(posedge CLK) disable iff (RST)
    $rose(sc_trip_q) && !$past(collapse) |-> $past(sc_c, 2))
    else $error("Short trip without held condition.");

  // Counts how long the collapse has lasted; a delay range cannot span it.
  always_ff @(posedge CLK) begin
    if (RST || !collapse) begin
      collapse_cnt_q <= '0;
    end else if (collapse_cnt_q != '1) begin
      collapse_cnt_q <= collapse_cnt_q + 1'b1;
    end
  end

  ssc_bound_a: assert property (@(posedge CLK) disable iff (RST)
    collapse_cnt_q >= QW'(SSCD_CYC + 2) |-> !DISCHARGE_GATE_OUT)
    else $error("Collapse did not drop discharge gate.");

  mode_gate_a: assert property (@(posedge CLK) disable iff (RST)
    protect_measure_mode != cpf_pkg::PMM_RUN |=> !CHARGE_GATE_OUT && !DISCHARGE_GATE_OUT)
    else $error("Gate high outside run mode.");

  sleep_gate_a: assert property (@(posedge CLK) disable iff (RST)
    SLEEP |=> !CHARGE_GATE_OUT && !DISCHARGE_GATE_OUT)
    else $error("Gate high while sleeping.");

  flag_sticky_a: assert property (@(posedge CLK) disable iff (RST)
    flags_q[4] && coc_trip_q |=> flags_q[4])
    else $error("Flag cleared while fault present.");

  temp_chg_a: assert property (@(posedge CLK) disable iff (RST)
    temp_en && temp_chg_q |=> !CHARGE_GATE_OUT)
    else $error("Charge gate high out of temperature.");

  // Main scenarios worth seeing.
  ov_trip_c: cover property (@(posedge CLK) disable iff (RST)
    $rose(ov_trip_q) ##[1:1000] $fell(ov_trip_q));
  sc_trip_c: cover property (@(posedge CLK) disable iff (RST)
    $rose(sc_trip_q));
  flag_clear_c: cover property (@(posedge CLK) disable iff (RST)
    $fell(flags_q[4]));
  temp_block_c: cover property (@(posedge CLK) disable iff (RST)
    temp_en && temp_dis_q);

endmodule

// *** rtl/cpf_qualify.sv ***
`timescale 1ns/1ps
// Counts how long a condition has held and fires once it outlasts the limit.
module cpf_qualify #(
  parameter int W = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Condition and delay.
  input wire logic cond,
  input wire logic [W-1:0] limit,
  output logic fired
);

  logic [W-1:0] cnt_q;

  // Any gap in the condition restarts the count from zero.
  always_ff @(posedge clk) begin
    if (rst || !cond) begin
      cnt_q <= '0;
    end else if (cnt_q != limit) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Fires on the cycle after the condition has held for limit cycles.
  assign fired = cond && (cnt_q == limit);

  restart_count_a: assert property (@(posedge clk) disable iff (rst)
    !cond |=> cnt_q == '0)
    else $error("Qualify count did not restart.");

endmodule

// *** rtl/cpf_sync.sv ***
`timescale 1ns/1ps
// Two-stage synchroniser for a bundle of independent comparator levels.
module cpf_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Levels.
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

// *** verification/cell_protection_fsm_tb_top.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  fail_count++; $display("unexpected at %0t: got %h expected %h", \
  $time, (g), (e)); end end
`define WAITFOR(c) begin n = 0; while (!(c) && n < 40) begin \
  @(posedge clk); #1; n++; end if (!(c)) begin fail_count++; \
  print_verdict(); end end
module cell_protection_fsm_tb_top;
  // Stimulus, observed outputs and tallies.
  logic clk = '0, rst = '1, wr = '0, rd = '0, ov = '0, ce = '0, uv = '0;
  logic nn = '1, d2 = '0, sup = '0, tu = '0, slp = '0, chg = '0, ld = '0;
  logic [3:0] addr = '0, charge_overcurrent_fault = '0, noc = '0, sc = '0;
  logic [15:0] wd = '0, rdat;
  logic signed [15:0] tv = '0;
  logic cc_o, dc_o, pd, pu, rec, adc, pl, ph;
  int fail_count = 0, samples_checked = 0, n;

  // Short delays keep the run brief; the long short-circuit delay
  // differs so that the delay select bit is visible.
  cpf_protect #(.OVD_CYC(4), .UVD_CYC(4), .OCD_CYC(4),
    .SCD_SHORT_CYC(4), .SCD_LONG_CYC(12)) u_dut (
    .CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wd), .WR(wr), .RD(rd),
    .RDATA(rdat), .CELL_ABOVE_OV(ov), .CELL_BELOW_CE(ce),
    .CELL_BELOW_UV(uv), .CELL_NONNEG(nn), .SENSE_ABOVE_COC(charge_overcurrent_fault),
    .SENSE_BELOW_NOC(noc), .SENSE_ABOVE_SC(sc), .SENSE_DISCHG_2MV(d2),
    .PACK_TERMINAL_LOW(pl), .PACK_TERMINAL_HIGH(ph),
    .SUPPLY_COLLAPSED(sup), .TEMP_VALUE(tv), .TEMP_UPDATE(tu),
    .SLEEP(slp), .CHARGE_GATE_OUT(cc_o), .DISCHARGE_GATE_OUT(dc_o),
    .PACK_PULLDOWN_EN(pd), .PACK_PULLUP_EN(pu), .RECOVERY_EN(rec),
    .ADC_EN(adc));

  // Far side of the pack terminal.
  cpf_pack_model u_pack (.clk(clk), .pulldown_en(pd), .pullup_en(pu),
    .charger_on(chg), .load_on(ld), .pack_low(pl), .pack_high(ph));

  // 20 MHz clock.
  always #25 clk = ~clk;

  // Ends the run; the only place that prints the verdict.
  task print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Waits k edges, then steps past the edge so outputs have settled.
  task wt(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // One-cycle register write.
  task wrr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk) addr <= a;
    wd <= d;
    wr <= '1;
    @(posedge clk) wr <= '0;
  endtask

  // One-cycle read; data stand only in the following cycle.
  task rdc(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk) addr <= a;
    rd <= '1;
    @(posedge clk) rd <= '0;
    #1;
    `CHK(rdat, e)
  endtask

  // Presents one temperature result and checks both gates.
  task tp(input logic signed [15:0] v, input logic [1:0] e);
    @(posedge clk) tv <= v;
    tu <= '1;
    @(posedge clk) tu <= '0;
    wt(3);
    `CHK({cc_o, dc_o}, e)
  endtask

  task t_regs;
    rdc(4'h0, 16'h030F);
    rdc(4'h2, 16'h0000);
    wrr(4'h5, 16'hFFFF);
    rdc(4'h5, 16'h0000);
    wrr(4'h1, 16'hFFFF);
    rdc(4'h1, 16'hFFF9);
    wrr(4'h1, 16'h0000);
    wrr(4'h0, 16'hF80F);
    rdc(4'h0, 16'h030F);
  endtask

  task t_mode;
    for (int m = 0; m < 4; m++) begin
      wrr(4'h0, {14'h0003, m[1:0]});
      wt(3);
      `CHK({adc, cc_o, dc_o}, {m != 0, m == 3, m == 3})
    end
    wrr(4'h0, 16'h0007);
    wt(3);
    `CHK({cc_o, dc_o}, 2'h1)
    wrr(4'h0, 16'h000B);
    wt(3);
    `CHK({cc_o, dc_o}, 2'h2)
    wrr(4'h0, 16'h000F);
    @(posedge clk) slp <= '1;
    wt(3);
    `CHK({cc_o, dc_o}, 2'h0)
    @(posedge clk) slp <= '0;
    wt(4);
    `CHK({cc_o, dc_o}, 2'h3)
  endtask

  // Both release paths: falling below charge-enable, then discharge.
  task t_ov;
    for (int k = 0; k < 2; k++) begin
      @(posedge clk) ov <= '1;
      `WAITFOR(!cc_o)
      `CHK(dc_o, 1'h1)
      wrr(4'h0, 16'h000F);
      rdc(4'h0, 16'h110F);
      @(posedge clk) ov <= '0;
      wt(8);
      `CHK(cc_o, 1'h0)
      @(posedge clk) if (k == 0) ce <= '1; else d2 <= '1;
      wt(8);
      `CHK(cc_o, 1'h1)
      @(posedge clk) ce <= '0;
      d2 <= '0;
      wrr(4'h0, 16'h000F);
      rdc(4'h0, 16'h030F);
    end
  endtask

  // Runs of four held cycles, each broken one short of the trip.
  task t_qual;
    repeat (5) begin
      @(posedge clk) ov <= '1;
      repeat (4) @(posedge clk);
      ov <= '0;
    end
    wt(10);
    rdc(4'h0, 16'h030F);
  endtask

  task t_uv;
    @(posedge clk) uv <= '1;
    `WAITFOR(!cc_o && !dc_o)
    rdc(4'h0, 16'h080F);
    @(posedge clk) ce <= '1;
    wt(4);
    `CHK(rec, 1'h1)
    @(posedge clk) nn <= '0;
    wt(4);
    `CHK(rec, 1'h0)
    @(posedge clk) nn <= '1;
    ce <= '0;
    wt(4);
    `CHK(rec, 1'h0)
    @(posedge clk) uv <= '0;
    wt(8);
    `CHK({cc_o, dc_o}, 2'h3)
    wrr(4'h0, 16'h000F);
    rdc(4'h0, 16'h030F);
  endtask

  task t_coc;
    for (int s = 0; s < 4; s++) begin
      wrr(4'h1, {8'h00, s[1:0], 6'h00});
      @(posedge clk) charge_overcurrent_fault <= 4'h1 << ((s + 1) % 4);
      wt(12);
      `CHK(cc_o, 1'h1)
      @(posedge clk) charge_overcurrent_fault <= 4'h1 << s;
      chg <= '1;
      `WAITFOR(!cc_o && !dc_o)
      `CHK(pd, 1'h1)
      @(posedge clk) charge_overcurrent_fault <= 4'h0;
      wt(8);
      `CHK(cc_o, 1'h0)
      @(posedge clk) chg <= '0;
      `WAITFOR(cc_o && dc_o)
      `CHK(pd, 1'h0)
      rdc(4'h0, 16'h830F);
      wrr(4'h0, 16'h000F);
      rdc(4'h0, 16'h030F);
    end
  endtask

  // Even passes trip on overcurrent, odd ones on short circuit.
  task t_dsc;
    for (int k = 0; k < 4; k++) begin
      wrr(4'h1, {10'h000, k[1:0], k[1], 3'h0});
      @(posedge clk) ld <= '1;
      if (k[0]) sc <= 4'h1 << k;
      else noc <= 4'h1 << k;
      wt(10);
      `CHK(dc_o, k == 3)
      `WAITFOR(!dc_o)
      `CHK({cc_o, pu}, 2'h3)
      @(posedge clk) sc <= 4'h0;
      noc <= 4'h0;
      wt(8);
      `CHK(dc_o, 1'h0)
      @(posedge clk) ld <= '0;
      `WAITFOR(dc_o)
      rdc(4'h0, k[0] ? 16'h230F : 16'h430F);
      wrr(4'h0, 16'h000F);
      rdc(4'h0, 16'h030F);
    end
  endtask

  task t_sup;
    @(posedge clk) sup <= '1;
    wt(cpf_pkg::SSCD_CYC + 6);
    `CHK(dc_o, 1'h0)
    @(posedge clk) sup <= '0;
    `WAITFOR(dc_o)
    wrr(4'h0, 16'h000F);
    rdc(4'h0, 16'h030F);
  endtask

  // Values are eighths of a degree around the selected limits.
  task t_temp;
    tp(16'h07D0, 2'h3); // Gating off at 250 C
    wrr(4'h2, 16'h0004);
    tp(16'h01A9, 2'h1); // Just above charge-high
    tp(16'h01A8, 2'h3); // At charge-high, released at once
    tp(16'hFFE8, 2'h1); // At charge-low
    tp(16'hFFE9, 2'h3); // Just above charge-low
    tp(16'h01F9, 2'h0); // Above discharge-high
    tp(16'hFF48, 2'h0); // At discharge-low
    wrr(4'h2, 16'h0007);
    tp(16'h02C0, 2'h3); // At the wider high limit
    tp(16'h02C1, 2'h0); // Above it
    tp(16'h0000, 2'h3);
    wrr(4'h2, 16'h0000);
  endtask

  // Reset for eight cycles, then every scenario in turn.
  initial begin
    repeat (8) @(posedge clk);
    rst <= '0;
    wt(4);
    t_regs;
    t_mode;
    t_ov;
    t_qual;
    t_uv;
    t_coc;
    t_dsc;
    t_sup;
    t_temp;
    print_verdict;
  end
endmodule

// *** verification/cpf_pack_model.sv ***
`timescale 1ns/1ps
// Charger, load and pack terminal beyond the external FETs.
module cpf_pack_model (
  // Clock.
  input wire logic clk,
  // Test currents from the block.
  input wire logic pulldown_en,
  input wire logic pullup_en,
  // Offenders that the bench connects or removes.
  input wire logic charger_on,
  input wire logic load_on,
  // Terminal comparator levels.
  output logic pack_low,
  output logic pack_high
);
  // A live charger or load overpowers the weak test current, so the
  // terminal only moves once the offender has gone; one cycle of lag
  // stands in for the terminal settling.
  always_ff @(posedge clk) begin
    pack_low <= pulldown_en && !charger_on;
    pack_high <= pullup_en && !load_on;
  end
endmodule
